//--- i2cms_pkg.sv
// Package of register offsets, field positions and timing constants for the I2C stop/baud/status block.
`default_nettype none
package i2cms_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [4:0] OFF_STATUS  = 5'h00;
    localparam logic [4:0] OFF_BUFFER  = 5'h04;
    localparam logic [4:0] OFF_CTRL1   = 5'h08;
    localparam logic [4:0] OFF_CTRL2   = 5'h0c;
    localparam logic [4:0] OFF_CTRL3   = 5'h10;
    localparam logic [4:0] OFF_RELOAD  = 5'h14;
    localparam logic [4:0] OFF_MASK    = 5'h18;
    localparam logic [4:0] OFF_EVENTS  = 5'h1c;
    // Status field positions.
    localparam int ST_SAMPLE = 7;
    localparam int ST_EDGE   = 6;
    localparam int ST_DATA   = 5;
    localparam int ST_STOP   = 4;
    localparam int ST_START  = 3;
    localparam int ST_RW     = 2;
    localparam int ST_UA     = 1;
    localparam int ST_BF     = 0;
    // Control one and two field positions.
    localparam int C1_EN     = 5;
    localparam int C2_ACK    = 4;
    localparam int C2_RCV    = 3;
    localparam int C2_STOP   = 2;
    localparam int C2_RST    = 1;
    localparam int C2_START  = 0;
    // Mode codes in control one low nibble.
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_BRG    = 4'ha;
    // Instruction cycle is one quarter of the oscillator rate.
    localparam logic [1:0] CY_DIV_LAST = 2'h3;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Stop sequence states.
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_SDA_LOW  = 3'b001,
        ST_SCL_REL  = 3'b010,
        ST_SCL_HIGH = 3'b011,
        ST_SDA_REL  = 3'b100,
        ST_FINAL    = 3'b101
    } i2cms_stop_e;

    // Open-drain line drive to the pads.
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } i2cms_drive_s;
endpackage : i2cms_pkg
`default_nettype wire

//--- i2cms_top.sv
// Stop generation with collision check, shared baud counter and port status over AXI4-Lite.
`default_nettype none
module i2cms_top
    import i2cms_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // AXI4-Lite slave.
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // I2C lines, open drain.
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Events from the shifter, detector and slave logic.
    input  wire logic        start_seen,
    input  wire logic        stop_seen,
    input  wire logic        byte_done,
    input  wire logic        byte_is_data,
    input  wire logic        byte_received,
    input  wire logic        tx_data_active,
    input  wire logic        addr_match,
    input  wire logic        addr_rw,
    input  wire logic        nack_seen,
    input  wire logic        addr_update,
    input  wire logic        buffer_read,
    input  wire logic        op_done,
    // Outputs to the shifter and pads.
    output logic             baud_tick,
    output logic             spi_sample_end,
    output logic             spi_tx_active_edge,
    output logic             slew_disable,
    output logic             smbus_levels,
    output logic             port_busy
);

    logic [7:0]  shift_buffer;
    logic [7:0]  port_control_one;
    logic [7:0]  port_control_two;
    logic [7:0]  port_control_three;
    logic [7:0]  baud_reload_address;
    logic [7:0]  address_mask;
    logic [1:0]  sample_edge;
    logic        collision_flag;
    logic        last_data, stop_last, start_last, dir_bit, update_flag, buffer_full;
    logic        tx_busy;
    logic [7:0]  baud_counter;
    logic        counting;
    logic [1:0]  cy_div;
    logic        cy_en;
    logic        expired;
    logic        scl_s1, scl_s2, sda_s1, sda_s2;
    i2cms_stop_e stop_state;
    i2cms_drive_s drive;
    logic        collide;
    logic        stop_clear;
    logic        aw_hold, w_hold;
    logic [4:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_fire;
    logic        buf_wr;
    logic        port_enable;
    logic        master_mode;

    assign port_enable = port_control_one[C1_EN];
    assign master_mode = port_control_one[3:0] == MODE_I2C_MASTER;

    // Two-stage synchronisers for the bus lines.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end
        else
        begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
        end
    end

    // AXI write channel: address and data taken in either order.
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign wr_fire       = aw_hold && w_hold;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_fire)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr > OFF_EVENTS || aw_addr[1:0] != 2'h0)
                                ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Strobe into the written register; byte lane zero carries the data.
    logic wr_lane;
    assign wr_lane = wr_fire && s_axi_wstrb[0];
    assign buf_wr  = wr_lane && aw_addr == OFF_BUFFER;

    // Plain software registers.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            port_control_one    <= RESET_BYTE;
            port_control_three  <= RESET_BYTE;
            baud_reload_address <= RESET_BYTE;
            address_mask        <= RESET_BYTE;
            shift_buffer        <= RESET_BYTE;
            sample_edge         <= 2'h0;
        end
        else if (wr_lane)
        begin
            case (aw_addr)
                OFF_CTRL1:  port_control_one    <= w_data[7:0];
                OFF_CTRL3:  port_control_three  <= w_data[7:0];
                OFF_RELOAD: baud_reload_address <= w_data[7:0];
                OFF_MASK:   address_mask        <= w_data[7:0];
                OFF_BUFFER: shift_buffer        <= w_data[7:0];
                OFF_STATUS: sample_edge         <= w_data[ST_SAMPLE:ST_EDGE];
                default:    ;
            endcase
        end
    end

    // Mode-dependent meanings of sample phase and edge select.
    assign spi_sample_end     = !master_mode && sample_edge[1];
    assign slew_disable       = master_mode && sample_edge[1];
    assign spi_tx_active_edge = !master_mode && sample_edge[0];
    assign smbus_levels       = master_mode && sample_edge[0];

    // Sequence request bits; hardware clears stop on completion or collision.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            port_control_two <= RESET_BYTE;
        else if (!port_enable)
            port_control_two <= RESET_BYTE;
        else if (collide)
            port_control_two[C2_ACK:C2_START] <= '0;
        else if (stop_clear)
            port_control_two[C2_STOP] <= 1'b0;
        else if (wr_lane && aw_addr == OFF_CTRL2)
            port_control_two <= w_data[7:0] | {3'h0, port_control_two[4:0]};
        else if (op_done)
            port_control_two[C2_RCV] <= 1'b0;
    end

    // Instruction cycle enable: one pulse per four oscillator cycles.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cy_div <= 2'h0;
        else
            cy_div <= cy_div + 2'h1;
    end
    assign cy_en = cy_div == CY_DIV_LAST;

    // Shared baud counter, reloaded at each expiry so one reload per tick period.
    logic stop_load;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            baud_counter <= RESET_BYTE;
            counting     <= 1'b0;
        end
        else if (buf_wr || stop_load)
        begin
            baud_counter <= baud_reload_address;
            counting     <= 1'b1;
        end
        else if (op_done || collide || !port_enable)
            counting <= 1'b0;
        else if (counting && cy_en)
        begin
            if (baud_counter == RESET_BYTE)
                baud_counter <= baud_reload_address;
            else
                baud_counter <= baud_counter - 8'h01;
        end
    end
    assign expired   = counting && cy_en && baud_counter == RESET_BYTE;
    assign baud_tick = expired;

    // Stop sequence with collision detection.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stop_state <= ST_IDLE;
            drive      <= '0;
        end
        else if (!port_enable || collide)
        begin
            stop_state <= ST_IDLE;
            drive      <= '0;
        end
        else
        begin
            case (stop_state)
                ST_IDLE:
                    if (master_mode && port_control_two[C2_STOP])
                    begin
                        stop_state <= ST_SDA_LOW;
                        drive      <= '{scl_oe: 1'b1, sda_oe: 1'b1};
                    end
                ST_SDA_LOW:
                    if (!sda_s2)
                    begin
                        stop_state   <= ST_SCL_REL;
                        drive.scl_oe <= 1'b0;
                    end
                ST_SCL_REL:
                    if (scl_s2)
                        stop_state <= ST_SCL_HIGH;
                ST_SCL_HIGH:
                    if (expired)
                    begin
                        stop_state   <= ST_SDA_REL;
                        drive.sda_oe <= 1'b0;
                    end
                ST_SDA_REL:
                    if (expired)
                        stop_state <= ST_FINAL;
                ST_FINAL:
                    stop_state <= ST_IDLE;
                default:
                    stop_state <= ST_IDLE;
            endcase
        end
    end
    assign stop_load  = stop_state == ST_SCL_REL && scl_s2;
    assign stop_clear = stop_state == ST_FINAL;
    // SDA low after release plus count, or SCL low before SDA release.
    assign collide = (stop_state == ST_SDA_REL && expired && !sda_s2)
                  || (stop_state == ST_SCL_HIGH && !scl_s2);
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = drive.scl_oe;
    assign sda_oe  = drive.sda_oe;

    // Sticky collision flag; software writes one to clear, a new event wins.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            collision_flag <= 1'b0;
        else if (collide)
            collision_flag <= 1'b1;
        else if (wr_lane && aw_addr == OFF_EVENTS && w_data[0])
            collision_flag <= 1'b0;
    end

    // Start and stop most-recent flags.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            start_last <= 1'b0;
            stop_last  <= 1'b0;
        end
        else if (!port_enable)
        begin
            start_last <= 1'b0;
            stop_last  <= 1'b0;
        end
        else if (stop_seen || stop_clear)
        begin
            stop_last  <= 1'b1;
            start_last <= 1'b0;
        end
        else if (start_seen)
        begin
            start_last <= 1'b1;
            stop_last  <= 1'b0;
        end
    end

    // Data/address, direction, address update and transmit state.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            last_data   <= 1'b0;
            dir_bit     <= 1'b0;
            update_flag <= 1'b0;
            tx_busy     <= 1'b0;
        end
        else
        begin
            if (byte_done)
                last_data <= byte_is_data;
            if (addr_match)
                dir_bit <= addr_rw;
            else if (start_seen || stop_seen || nack_seen)
                dir_bit <= 1'b0;
            if (addr_update)
                update_flag <= 1'b1;
            else if (wr_lane && aw_addr == OFF_RELOAD)
                update_flag <= 1'b0;
            tx_busy <= master_mode && tx_data_active && !collide;
        end
    end

    // Buffer full: set on receive, held during data transmit, event wins.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            buffer_full <= 1'b0;
        else if (byte_received || (tx_data_active && !collide))
            buffer_full <= 1'b1;
        else if (buffer_read || collide || (!tx_data_active && tx_busy))
            buffer_full <= 1'b0;
    end

    assign port_busy = (master_mode ? tx_busy : 1'b0)
                     | (|port_control_two[C2_ACK:C2_START]);

    // Status byte as software sees it.
    logic [7:0] status_byte;
    assign status_byte = {sample_edge, last_data, stop_last, start_last,
                          master_mode ? tx_busy : dir_bit, update_flag, buffer_full};

    // AXI read channel; one cycle to the answer.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                OFF_STATUS: s_axi_rdata <= {24'h0, status_byte};
                OFF_BUFFER: s_axi_rdata <= {24'h0, shift_buffer};
                OFF_CTRL1:  s_axi_rdata <= {24'h0, port_control_one};
                OFF_CTRL2:  s_axi_rdata <= {24'h0, port_control_two};
                OFF_CTRL3:  s_axi_rdata <= {24'h0, port_control_three};
                OFF_RELOAD: s_axi_rdata <= {24'h0, baud_reload_address};
                OFF_MASK:   s_axi_rdata <= {24'h0, address_mask};
                OFF_EVENTS: s_axi_rdata <= {31'h0, collision_flag};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks.
    AST_STOP_SDA_COLLIDE: assert property (@(posedge mclk) disable iff (rst)
        stop_state == ST_SDA_REL && expired && !sda_s2 |=> collision_flag)
        else $error("Stop SDA collision not flagged.");
    AST_STOP_SCL_COLLIDE: assert property (@(posedge mclk) disable iff (rst)
        stop_state == ST_SCL_HIGH && !scl_s2 && port_enable
        |=> stop_state == ST_IDLE && !drive.sda_oe)
        else $error("Stop SCL collision did not abort.");
    sequence seq_scl_up;
        stop_state == ST_SCL_REL && scl_s2;
    endsequence
    AST_STOP_LOAD: assert property (@(posedge mclk) disable iff (rst)
        seq_scl_up |=> counting && baud_counter == baud_reload_address)
        else $error("Counter not loaded after SCL high.");
    AST_BUF_START: assert property (@(posedge mclk) disable iff (rst)
        buf_wr |=> counting)
        else $error("Buffer write did not start counter.");
    AST_DONE_STOP: assert property (@(posedge mclk) disable iff (rst)
        op_done && !buf_wr && !stop_load |=> !counting)
        else $error("Counter kept running after completion.");
    AST_DISABLE_FLAGS: assert property (@(posedge mclk) disable iff (rst)
        !port_enable |=> !start_last && !stop_last)
        else $error("Start/stop flags survive disable.");
    AST_STOP_FLAG: assert property (@(posedge mclk) disable iff (rst)
        port_enable && stop_seen |=> stop_last || !port_enable)
        else $error("Stop flag not set.");
    AST_RX_FULL: assert property (@(posedge mclk) disable iff (rst)
        byte_received |=> buffer_full)
        else $error("Buffer full not set on receive.");
    AST_COLLIDE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        collide |=> !port_control_two[C2_STOP] && !drive.scl_oe)
        else $error("Collision did not clear request.");

endmodule : i2cms_top
`default_nettype wire

//--- i2cms_bus_model.sv
// Far side of the two-wire bus: pull-ups plus another party that may pull either line low.
`default_nettype none
module i2cms_bus_model
(
    // Pull-down drives from the block and from the far party.
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic far_scl_low,
    input  wire logic far_sda_low,
    // Resolved line levels.
    output logic      scl_line,
    output logic      sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // A line floats high through its pull-up unless some party pulls it low.
    assign scl_line = !(scl_oe || far_scl_low);
    assign sda_line = !(sda_oe || far_sda_low);
endmodule : i2cms_bus_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the register bus, baud counter, stop sequence and status flags.
`default_nettype none
module testbench;
    import i2cms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Compare helper and bounded wait at the falling edge.
    `define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin miscompares++; \
        $display("wrong value %s exp %0h got %0h", nm, e, g); end end
    `define WAITN(c) @(negedge mclk); for (n = 0; n < 3000 && !(c); n++) @(negedge mclk); \
        if (!(c)) fail_out();
    // Stimulus and observed signals.
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic [4:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = '0;
    logic [11:0] ev = '0;
    logic        far_scl = 1'h0, far_sda = 1'h0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic   scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, baud_tick, port_busy;
    wire logic   spi_sample_end, spi_tx_active_edge, slew_disable, smbus_levels;
    int          miscompares = 0, total_checks = 0, seed = 32'h24867e57, n, k, i;
    logic [7:0]  v;
    logic [33:0] expq[$];
    logic [33:0] e0;

    // Block under test and the far side of its bus.
    i2cms_top i2cms_top_i (.*, .start_seen(ev[0]), .stop_seen(ev[1]), .byte_done(ev[2]),
        .byte_is_data(ev[3]), .byte_received(ev[4]), .tx_data_active(ev[5]),
        .addr_match(ev[6]), .addr_rw(ev[7]), .nack_seen(ev[8]), .addr_update(ev[9]),
        .buffer_read(ev[10]), .op_done(ev[11]));
    i2cms_bus_model i2cms_bus_model_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .far_scl_low(far_scl),
        .far_sda_low(far_sda), .scl_line(scl_in), .sda_line(sda_in));

    // Clock of 4 ns.
    initial
        forever #2 mclk = ~mclk;

    // Read results are matched in order against the notes left by the read task.
    always @(posedge mclk)
        if (s_axi_rvalid && s_axi_rready)
        begin
            e0 = expq.pop_front();
            `CHK("read word", e0, {s_axi_rresp, s_axi_rdata})
        end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic fail_out();
        miscompares++;
        give_verdict();
    endtask : fail_out

    // Bus write: address and data offered together, response awaited.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        `WAITN(s_axi_awready && s_axi_wready)
        @(posedge mclk);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        `WAITN(s_axi_bvalid)
        @(posedge mclk);
        s_axi_bready <= 1'h0;
    endtask : wr

    // Bus read: the expected word is noted before the request goes out.
    task automatic rd(input logic [4:0] a, input logic [1:0] r, input logic [7:0] d);
        expq.push_back({r, 24'h0, d});
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        `WAITN(s_axi_arready)
        @(posedge mclk);
        s_axi_arvalid <= 1'h0;
        `WAITN(s_axi_rvalid)
        @(posedge mclk);
        s_axi_rready <= 1'h0;
    endtask : rd

    // One-cycle pulse on the selected event inputs.
    task automatic pulse(input logic [11:0] m);
        @(posedge mclk);
        ev <= ev | m;
        @(posedge mclk);
        ev <= ev & ~m;
    endtask : pulse

    // Main sequence.
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        rd(OFF_STATUS, RESP_OKAY, RESET_BYTE);
        rd(5'h01, RESP_SLVERR, 8'h00);
        // Phase and edge selections in both port kinds.
        for (i = 0; i < 6; i++)
        begin
            v = 8'($random(seed));
            wr(OFF_CTRL1, i[0] ? 8'h28 : 8'h2a);
            wr(OFF_STATUS, {v[1:0], 6'h00});
            @(negedge mclk);
            if (i[0])
            begin
                `CHK("slew", v[1], slew_disable)
                `CHK("smbus", v[0], smbus_levels)
            end
            else
            begin
                `CHK("sample end", v[1], spi_sample_end)
                `CHK("tx edge", v[0], spi_tx_active_edge)
            end
            rd(OFF_STATUS, RESP_OKAY, {v[1:0], 6'h00});
        end
        // Counter period, start by buffer write, halt on completion.
        wr(OFF_CTRL1, 8'h2a);
        wr(OFF_RELOAD, 8'h03);
        wr(OFF_BUFFER, 8'h5a);
        `WAITN(baud_tick)
        `WAITN(baud_tick)
        `CHK("tick period", 16, n + 1)
        pulse(12'h800);
        k = 0;
        repeat (60) @(negedge mclk) k += int'(baud_tick === 1'h1);
        `CHK("ticks after done", 0, k)
        // Stop sequence: clean, far side holding data low, far side bumping the clock.
        wr(OFF_STATUS, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            wr(OFF_CTRL1, 8'h08);
            wr(OFF_CTRL1, 8'h28);
            wr(OFF_EVENTS, 8'h01);
            far_sda <= (i == 1);
            wr(OFF_CTRL2, 8'h04);
            @(negedge mclk);
            `CHK("busy", 1'h1, port_busy)
            if (i == 2)
            begin
                `WAITN(!scl_oe && scl_in)
                repeat (4) @(posedge mclk);
                far_scl <= 1'h1;
                repeat (6) @(posedge mclk);
                far_scl <= 1'h0;
            end
            `WAITN(!port_busy)
            far_sda <= 1'h0;
            `CHK("scl drive", 1'h0, scl_oe)
            `CHK("sda drive", 1'h0, sda_oe)
            rd(OFF_CTRL2, RESP_OKAY, 8'h00);
            rd(OFF_EVENTS, RESP_OKAY, {7'h0, i != 0});
            rd(OFF_STATUS, RESP_OKAY, {3'h0, i == 0, 4'h0});
        end
        // Status events while enabled, then disable.
        wr(OFF_CTRL1, 8'h28);
        pulse(12'h21d);
        rd(OFF_STATUS, RESP_OKAY, 8'h2b);
        @(posedge mclk);
        ev[5] <= 1'h1;
        pulse(12'h400);
        wr(OFF_RELOAD, 8'h03);
        rd(OFF_STATUS, RESP_OKAY, 8'h2d);
        @(posedge mclk);
        ev[5] <= 1'h0;
        pulse(12'h002);
        rd(OFF_STATUS, RESP_OKAY, 8'h30);
        wr(OFF_CTRL1, 8'h08);
        rd(OFF_STATUS, RESP_OKAY, 8'h20);
        // Slave mode direction bit: set by a read address match, dropped on a missing acknowledge.
        wr(OFF_CTRL1, 8'h26);
        pulse(12'h0c0);
        rd(OFF_STATUS, RESP_OKAY, 8'h24);
        pulse(12'h100);
        rd(OFF_STATUS, RESP_OKAY, 8'h20);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
